// *** hdl/port_stats_defs.svh ***
// Port statistics constants: offsets, thresholds and reset values.
// Assumes a 32-bit APB register bus with aligned word registers.
`ifndef PORT_STATS_DEFS_SVH
`define PORT_STATS_DEFS_SVH

// Register byte offsets
`define OFS_BUCKET_EXACT_MIN  12'h000
`define OFS_BUCKET_SECOND     12'h004
`define OFS_BUCKET_THIRD      12'h008
`define OFS_BUCKET_FOURTH     12'h00C
`define OFS_BUCKET_FIFTH      12'h010
`define OFS_BUCKET_LARGEST    12'h014
`define OFS_LINK_UTIL_BYTES   12'h018
`define OFS_RX_START_OVERRUN  12'h01C
`define OFS_RX_MIDDLE_OVERRUN 12'h020
`define OFS_RX_DMA_OVERRUN    12'h024
`define OFS_MAX_RX_LEN        12'h028
`define OFS_STATS_CTRL        12'h02C

// Frame size thresholds in bytes
`define LEN_MIN_FRAME     16'h0040
`define LEN_SECOND_LO     16'h0041
`define LEN_SECOND_HI     16'h007F
`define LEN_THIRD_LO      16'h0080
`define LEN_THIRD_HI      16'h00FF
`define LEN_FOURTH_LO     16'h0100
`define LEN_FOURTH_HI     16'h01FF
`define LEN_FIFTH_LO      16'h0200
`define LEN_FIFTH_HI      16'h03FF
`define LEN_LARGEST_LO    16'h0400

// Reset values
`define RST_MAX_RX_LEN    16'h05EE
`define RST_STATS_CTRL    32'h0000_0000

// Control register field positions
`define CTRL_FREEZE_BIT   0
`define CTRL_CLEAR_BIT    1

`endif

// *** hdl/port_stats_pkg.sv ***
// Types shared by the port statistics block.
// Assumes the constants header is compiled alongside.
package port_stats_pkg;

	// Receive frame end report from the MAC receive path
	typedef struct packed {
		logic        valid;
		logic [15:0] length;
		logic        accepted;
		logic        sof_overrun;
		logic        mid_frame_overrun;
		logic        fifo_drop;
		logic        dma_sof_zero;
		logic        dma_mid_zero;
	} rx_report_t;

	// Transmit attempt end report from the MAC transmit path
	typedef struct packed {
		logic        valid;
		logic [15:0] length;
		logic        late_coll;
		logic        excess_coll;
		logic        carrier_err;
		logic        collision;
		logic        pause;
	} tx_report_t;

	// Size bucket one-hot
	typedef struct packed {
		logic largest;
		logic fifth;
		logic fourth;
		logic third;
		logic second;
		logic exact_min;
	} bucket_hit_t;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_SETUP = 2'b01,
		ACC_DONE  = 2'b10
	} apb_phase_t;

endpackage

// *** hdl/size_bucket_classify.sv ***
// Maps one frame length onto the size bucket it falls into.
// Assumes the length is the byte count of a frame that qualifies.
`timescale 1ns/1ns
`default_nettype none
`include "port_stats_defs.svh"

module size_bucket_classify (
	input  wire logic [15:0]               len_i,
	input  wire logic [15:0]               max_len_i,
	input  wire logic                      is_rx_i,
	input  wire logic                      qualify_i,
	output wire port_stats_pkg::bucket_hit_t hit_o
);
	import port_stats_pkg::*;

	wire in_largest = (len_i >= `LEN_LARGEST_LO) &&
		(!is_rx_i || len_i <= max_len_i);

	// Bucket ranges never overlap
	assign hit_o.exact_min = qualify_i && (len_i == `LEN_MIN_FRAME);
	assign hit_o.second    = qualify_i && (len_i >= `LEN_SECOND_LO) &&
		(len_i <= `LEN_SECOND_HI);
	assign hit_o.third     = qualify_i && (len_i >= `LEN_THIRD_LO) &&
		(len_i <= `LEN_THIRD_HI);
	assign hit_o.fourth    = qualify_i && (len_i >= `LEN_FOURTH_LO) &&
		(len_i <= `LEN_FOURTH_HI);
	assign hit_o.fifth     = qualify_i && (len_i >= `LEN_FIFTH_LO) &&
		(len_i <= `LEN_FIFTH_HI);
	assign hit_o.largest   = qualify_i && in_largest;

endmodule // size_bucket_classify
`default_nettype wire

// *** hdl/port_frame_statistics.sv ***
// Per-port frame statistics counters with an APB register slave.
// Assumes one end report per rx frame and per tx attempt from the MAC paths,
// synchronous to core_clk_i, and a standard APB master.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "port_stats_defs.svh"

module port_frame_statistics #(
	parameter int CNT_W = 32
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_n_i,
	// APB slave
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [11:0]            paddr_i,
	input  wire logic [31:0]            pwdata_i,
	input  wire logic [3:0]             pstrb_i,
	output logic                        pready_o,
	output logic [31:0]                 prdata_o,
	output logic                        pslverr_o,
	// Frame reports
	input  wire port_stats_pkg::rx_report_t rx_rep_i,
	input  wire port_stats_pkg::tx_report_t tx_rep_i,
	input  wire logic                   rx_jam_start_i,
	input  wire logic [15:0]            rx_bytes_before_jam_i
);
	import port_stats_pkg::*;

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	function automatic logic [CNT_W-1:0] bump(
		input logic [CNT_W-1:0] cur,
		input logic             hit
	);
		bump = hit ? cur + CNT_W'(1) : cur;
	endfunction

	function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
		widen = 32'(v);
	endfunction

	// ----------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------
	logic [15:0]      max_rx_frame_length_q;
	logic             freeze_q;

	// ----------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------
	wire access     = psel_i && penable_i;
	wire wr_access  = access && pwrite_i;
	wire sel_maxlen = paddr_i == `OFS_MAX_RX_LEN;
	wire sel_ctrl   = paddr_i == `OFS_STATS_CTRL;
	wire addr_ok    = (paddr_i[1:0] == 2'b00) &&
		(paddr_i <= `OFS_STATS_CTRL);
	wire clear_req  = wr_access && sel_ctrl && pstrb_i[0] &&
		pwdata_i[`CTRL_CLEAR_BIT];
	wire ctr_en     = !freeze_q;

	assign pready_o  = 1'b1;
	assign pslverr_o = access && !addr_ok;

	// ----------------------------------------------------------
	// Frame qualification
	// ----------------------------------------------------------
	// Errors such as CRC or underrun are not inputs here at all
	wire tx_bad     = tx_rep_i.late_coll || tx_rep_i.excess_coll ||
		tx_rep_i.carrier_err;
	// Carrier-lost 64-byte transmit still lands in the min bucket
	wire tx_cl_min  = tx_rep_i.carrier_err && !tx_rep_i.late_coll &&
		!tx_rep_i.excess_coll &&
		(tx_rep_i.length == `LEN_MIN_FRAME);
	// A retried collision attempt is not a finished frame
	wire tx_final   = tx_rep_i.valid && !tx_rep_i.collision;
	wire tx_qual    = tx_final && (!tx_bad || tx_cl_min);
	wire rx_qual    = rx_rep_i.valid;

	wire [15:0] tx_len_eff = tx_rep_i.pause ? `LEN_MIN_FRAME :
		tx_rep_i.length;

	bucket_hit_t rx_hit;
	bucket_hit_t tx_hit;

	size_bucket_classify u_rx_class (
		.len_i     (rx_rep_i.length),
		.max_len_i (max_rx_frame_length_q),
		.is_rx_i   (1'b1),
		.qualify_i (rx_qual),
		.hit_o     (rx_hit)
	);

	size_bucket_classify u_tx_class (
		.len_i     (tx_len_eff),
		.max_len_i (max_rx_frame_length_q),
		.is_rx_i   (1'b0),
		.qualify_i (tx_qual),
		.hit_o     (tx_hit)
	);

	// ----------------------------------------------------------
	// Counter state
	// ----------------------------------------------------------
	logic [CNT_W-1:0] size_bucket_exact_min_q;
	logic [CNT_W-1:0] size_bucket_second_q;
	logic [CNT_W-1:0] size_bucket_third_q;
	logic [CNT_W-1:0] size_bucket_fourth_q;
	logic [CNT_W-1:0] size_bucket_fifth_q;
	logic [CNT_W-1:0] size_bucket_largest_q;
	logic [CNT_W-1:0] link_utilisation_bytes_q;
	logic [CNT_W-1:0] rx_start_overrun_count_q;
	logic [CNT_W-1:0] rx_middle_overrun_count_q;
	logic [CNT_W-1:0] rx_dma_overrun_count_q;

	// Rx and tx may both hit one bucket in the same cycle
	function automatic logic [CNT_W-1:0] bump2(
		input logic [CNT_W-1:0] cur,
		input logic             a,
		input logic             b
	);
		bump2 = cur + CNT_W'(a) + CNT_W'(b);
	endfunction

	// ----------------------------------------------------------
	// Net octet sum
	// ----------------------------------------------------------
	// Every attempt, any size, any error, retries again each time
	wire [15:0] rx_oct = rx_rep_i.valid ? rx_rep_i.length :
		16'h0000;
	// Length reports bytes actually sent, pre-loss or pre-collision
	wire [15:0] tx_oct = tx_rep_i.valid ? tx_rep_i.length :
		16'h0000;
	// Bytes up to the jam, jam itself not included
	wire [15:0] jam_oct = rx_jam_start_i ? rx_bytes_before_jam_i :
		16'h0000;
	wire [CNT_W-1:0] oct_add = CNT_W'(rx_oct) + CNT_W'(tx_oct) +
		CNT_W'(jam_oct);

	// ----------------------------------------------------------
	// Overrun qualification
	// ----------------------------------------------------------
	wire rx_sof_hit = rx_rep_i.valid && rx_rep_i.accepted &&
		(rx_rep_i.sof_overrun || rx_rep_i.fifo_drop);
	wire rx_mid_hit = rx_rep_i.valid && rx_rep_i.accepted &&
		rx_rep_i.mid_frame_overrun;
	// No error flags reach this term
	wire rx_dma_hit = rx_rep_i.valid && rx_rep_i.accepted &&
		(rx_rep_i.dma_sof_zero || rx_rep_i.dma_mid_zero);

	// ----------------------------------------------------------
	// Config registers
	// ----------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			max_rx_frame_length_q <= `RST_MAX_RX_LEN;
			freeze_q              <= 1'b0;
		end else if (wr_access && sel_maxlen) begin
			if (pstrb_i[0])
				max_rx_frame_length_q[7:0] <= pwdata_i[7:0];
			if (pstrb_i[1])
				max_rx_frame_length_q[15:8] <= pwdata_i[15:8];
		end else if (wr_access && sel_ctrl && pstrb_i[0]) begin
			freeze_q <= pwdata_i[`CTRL_FREEZE_BIT];
		end
	end

	// ----------------------------------------------------------
	// Counters
	// ----------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			size_bucket_exact_min_q   <= '0;
			size_bucket_second_q      <= '0;
			size_bucket_third_q       <= '0;
			size_bucket_fourth_q      <= '0;
			size_bucket_fifth_q       <= '0;
			size_bucket_largest_q     <= '0;
			link_utilisation_bytes_q  <= '0;
			rx_start_overrun_count_q  <= '0;
			rx_middle_overrun_count_q <= '0;
			rx_dma_overrun_count_q    <= '0;
		end else if (clear_req) begin
			size_bucket_exact_min_q   <= '0;
			size_bucket_second_q      <= '0;
			size_bucket_third_q       <= '0;
			size_bucket_fourth_q      <= '0;
			size_bucket_fifth_q       <= '0;
			size_bucket_largest_q     <= '0;
			link_utilisation_bytes_q  <= '0;
			rx_start_overrun_count_q  <= '0;
			rx_middle_overrun_count_q <= '0;
			rx_dma_overrun_count_q    <= '0;
		end else if (ctr_en) begin
			size_bucket_exact_min_q <= bump2(size_bucket_exact_min_q,
				rx_hit.exact_min, tx_hit.exact_min);
			size_bucket_second_q <= bump2(size_bucket_second_q,
				rx_hit.second, tx_hit.second);
			size_bucket_third_q <= bump2(size_bucket_third_q,
				rx_hit.third, tx_hit.third);
			size_bucket_fourth_q <= bump2(size_bucket_fourth_q,
				rx_hit.fourth, tx_hit.fourth);
			size_bucket_fifth_q <= bump2(size_bucket_fifth_q,
				rx_hit.fifth, tx_hit.fifth);
			size_bucket_largest_q <= bump2(size_bucket_largest_q,
				rx_hit.largest, tx_hit.largest);
			link_utilisation_bytes_q <= link_utilisation_bytes_q +
				oct_add;
			rx_start_overrun_count_q <= bump(rx_start_overrun_count_q,
				rx_sof_hit);
			rx_middle_overrun_count_q <= bump(rx_middle_overrun_count_q,
				rx_mid_hit);
			rx_dma_overrun_count_q <= bump(rx_dma_overrun_count_q,
				rx_dma_hit);
		end
	end

	// ----------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------
	logic [31:0] rd_d;

	always_comb begin
		case (paddr_i)
			`OFS_BUCKET_EXACT_MIN:  rd_d = widen(size_bucket_exact_min_q);
			`OFS_BUCKET_SECOND:     rd_d = widen(size_bucket_second_q);
			`OFS_BUCKET_THIRD:      rd_d = widen(size_bucket_third_q);
			`OFS_BUCKET_FOURTH:     rd_d = widen(size_bucket_fourth_q);
			`OFS_BUCKET_FIFTH:      rd_d = widen(size_bucket_fifth_q);
			`OFS_BUCKET_LARGEST:    rd_d = widen(size_bucket_largest_q);
			`OFS_LINK_UTIL_BYTES:   rd_d = widen(link_utilisation_bytes_q);
			`OFS_RX_START_OVERRUN:  rd_d = widen(rx_start_overrun_count_q);
			`OFS_RX_MIDDLE_OVERRUN: rd_d = widen(rx_middle_overrun_count_q);
			`OFS_RX_DMA_OVERRUN:    rd_d = widen(rx_dma_overrun_count_q);
			`OFS_MAX_RX_LEN:        rd_d = {16'h0000, max_rx_frame_length_q};
			`OFS_STATS_CTRL:        rd_d = {31'h0, freeze_q};
			default:                rd_d = 32'h0000_0000;
		endcase
	end

	// Read data registered during setup, valid in the access phase
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= rd_d;
	end

endmodule // port_frame_statistics
`default_nettype wire

// *** verif/stats_apb_checker.sv ***
// Port-level bus checks for the frame statistics block.
// Assumes a bind onto port_frame_statistics, one clock domain.
`timescale 1ns/1ns
`default_nettype none
module stats_apb_checker (
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic        pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic acc;
	wire logic bad;
	wire logic rd;
	assign acc = psel_i && penable_i;
	assign bad = (paddr_i > 12'h02C) || (paddr_i[1:0] != 2'h0);
	assign rd  = acc && !pwrite_i;
	a_ready_high: assert property (pready_o)
		else $error("pready low");
	a_err_unmapped: assert property (acc && bad |-> pslverr_o)
		else $error("no error on unmapped access");
	a_err_mapped: assert property (acc && !bad |-> !pslverr_o)
		else $error("error on mapped access");
	a_err_idle: assert property (!acc |-> !pslverr_o)
		else $error("error outside access phase");
	a_rdata_hold: assert property (
		!$past(psel_i && !penable_i && !pwrite_i) |-> $stable(prdata_o))
		else $error("read data moved without read setup");
	a_unmapped_zero: assert property (rd && bad |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_clear_reads_low: assert property (
		rd && paddr_i == 12'h02C |-> prdata_o[31:1] == 31'h0)
		else $error("control upper bits set");
	a_maxlen_upper: assert property (
		rd && paddr_i == 12'h028 |-> prdata_o[31:16] == 16'h0)
		else $error("length register upper bits set");
endmodule // stats_apb_checker

bind port_frame_statistics stats_apb_checker chk (
	.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pready_o, .prdata_o, .pslverr_o
);
`default_nettype wire

// *** verif/mac_report_model.sv ***
// Model of the MAC paths and DMA engine issuing frame reports.
// Assumes the bench calls fire() one report set at a time.
`timescale 1ns/1ns
`default_nettype none
module mac_report_model (
	input  wire logic                   core_clk_i,
	output var port_stats_pkg::rx_report_t rx_rep_o,
	output var port_stats_pkg::tx_report_t tx_rep_o,
	output var logic                    jam_o,
	output var logic [15:0]             jam_bytes_o
);
	import port_stats_pkg::*;
	initial begin
		rx_rep_o = '0;
		tx_rep_o = '0;
		jam_o = 1'b0;
		jam_bytes_o = 16'h0000;
	end
	// One-cycle pulse, then stale fields inverted
	task automatic fire(input rx_report_t r, input tx_report_t t,
		input logic j, input logic [15:0] jb);
		@(posedge core_clk_i);
		rx_rep_o <= r;
		tx_rep_o <= t;
		jam_o <= j;
		jam_bytes_o <= jb;
		@(posedge core_clk_i);
		rx_rep_o <= '{length: ~r.length, default: 1'b0};
		tx_rep_o <= '{length: ~t.length, default: 1'b0};
		jam_o <= 1'b0;
		jam_bytes_o <= ~jb;
	endtask
endmodule // mac_report_model
`default_nettype wire

// *** verif/port_frame_statistics_test.sv ***
// Self-checking bench for the frame statistics block.
// Assumes the report model and checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module port_frame_statistics_test;
	import port_stats_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	rx_report_t  rx_rep;
	tx_report_t  tx_rep;
	logic        jam;
	logic [15:0] jam_b;
	logic [31:0] exp_r [10];
	logic [15:0] maxlen = 16'h05EE;
	logic        frozen = 1'b0;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          checked = 0;
	int          cycles = 0;
	localparam rx_report_t NR = '0;
	localparam tx_report_t NT = '0;

	always #4 core_clk_i = ~core_clk_i;

	port_frame_statistics dut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(4'hF), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o), .rx_rep_i(rx_rep),
		.tx_rep_i(tx_rep), .rx_jam_start_i(jam),
		.rx_bytes_before_jam_i(jam_b));
	mac_report_model m (.core_clk_i(core_clk_i), .rx_rep_o(rx_rep),
		.tx_rep_o(tx_rep), .jam_o(jam), .jam_bytes_o(jam_b));

	task automatic complete_run();
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (e !== g) begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	function automatic int bkt(logic [15:0] n, logic rx);
		if (n < 16'd64) return -1;
		if (n == 16'd64) return 0;
		if (n <= 16'd127) return 1;
		if (n <= 16'd255) return 2;
		if (n <= 16'd511) return 3;
		if (n <= 16'd1023) return 4;
		if (rx && n > maxlen) return -1;
		return 5;
	endfunction
	function automatic rx_report_t rf(logic [15:0] n, logic [5:0] f);
		return {1'b1, n, f};
	endfunction
	function automatic tx_report_t tf(logic [15:0] n, logic [4:0] f);
		return {1'b1, n, f};
	endfunction
	task automatic send(rx_report_t r, tx_report_t t, logic [15:0] jb);
		int i;
		m.fire(r, t, jb != 16'h0, jb);
		if (frozen) return;
		exp_r[6] += 32'(jb);
		if (r.valid) begin
			exp_r[6] += 32'(r.length);
			i = bkt(r.length, 1'b1);
			if (i >= 0) exp_r[i]++;
			if (r.accepted && (r.sof_overrun || r.fifo_drop)) exp_r[7]++;
			if (r.accepted && r.mid_frame_overrun) exp_r[8]++;
			if (r.accepted && (r.dma_sof_zero || r.dma_mid_zero)) exp_r[9]++;
		end
		if (t.valid) begin
			exp_r[6] += 32'(t.length);
			i = bkt(t.pause ? 16'd64 : t.length, 1'b0);
			if (!t.collision && !t.late_coll && !t.excess_coll && i >= 0
				&& (!t.carrier_err || t.length == 16'd64)) exp_r[i]++;
		end
	endtask
	task automatic check_all();
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk($sformatf("reg %0h", i * 4), exp_r[i], rd);
		end
	endtask

	task automatic t_reset();
		check_all();
		apb(1'b0, 12'h028, 32'h0);
		chk("max length", 32'h0000_05EE, rd);
		apb(1'b1, 12'h030, 32'h5);
		chk("unmapped error", 32'h1, {31'h0, er});
		apb(1'b0, 12'h006, 32'h0);
		chk("unaligned read data", 32'h0, rd);
		chk("unaligned read error", 32'h1, {31'h0, er});
		apb(1'b0, 12'h02C, 32'h0);
		chk("control after reset", 32'h0, rd);
	endtask
	task automatic t_buckets();
		logic [15:0] l [14] = '{64, 65, 127, 128, 255, 256, 511, 512,
			1023, 1024, 1518, 1519, 2000, 40};
		foreach (l[i]) begin
			send(rf(l[i], 6'h20), NT, 16'h0);
			send(NR, tf(l[i], 5'h00), 16'h0);
		end
		send(rf(16'd100, 6'h20), tf(16'd300, 5'h00), 16'h0);
		check_all();
	endtask
	task automatic t_tx_faults();
		logic [4:0] f [7] = '{5'h10, 5'h08, 5'h04, 5'h04, 5'h02, 5'h02, 5'h01};
		logic [15:0] l [7] = '{100, 200, 300, 64, 80, 80, 100};
		foreach (f[i]) send(NR, tf(l[i], f[i]), 16'h0);
		check_all();
	endtask
	task automatic t_overruns();
		logic [5:0] f [6] = '{6'h30, 6'h28, 6'h24, 6'h22, 6'h21, 6'h10};
		foreach (f[i]) send(rf(16'd70, f[i]), NT, 16'h0);
		check_all();
	endtask
	task automatic t_freeze_clear();
		apb(1'b1, 12'h02C, 32'h1);
		frozen = 1'b1;
		send(rf(16'd64, 6'h20), tf(16'd64, 5'h00), 16'h0);
		check_all();
		apb(1'b1, 12'h02C, 32'h0);
		frozen = 1'b0;
		apb(1'b1, 12'h02C, 32'h2);
		foreach (exp_r[i]) exp_r[i] = 32'h0;
		apb(1'b1, 12'h028, 32'h0401);
		maxlen = 16'h0401;
		send(rf(16'h0401, 6'h20), NT, 16'h0);
		send(rf(16'h0402, 6'h20), NT, 16'd50);
		check_all();
		apb(1'b0, 12'h02C, 32'h0);
		chk("control", 32'h0, rd);
	endtask

	initial begin
		foreach (exp_r[i]) exp_r[i] = 32'h0;
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_buckets();
		t_tx_faults();
		t_overruns();
		t_freeze_clear();
		complete_run();
	end
endmodule // port_frame_statistics_test
`default_nettype wire
